// ==== logic/vcrrb_defs.svh ====
// Register offsets, field positions, reset values for the default channel
// resource register bank. Assumes a 32-bit APB slave with byte addresses.
//
// Notes on behaviour
// - Arbitration capability reads 09h after reset
// - No time-based weighted round robin here
// - Advanced-switching-only bit always reads zero
// - Snoop-rejection capability bit reads zero
// - Max time slots resets 7Fh, loadable
// - Table location field resets to 04h
// - Traffic class map writable, resets FFh, loadable
// - Table-load bit triggers load, reads zero
// - Scheme select accepts 000b/011b, else default
// - Channel identifier reads 000b always
// - Channel enable writable, resets to one
// - Table status sets on any table write
// - Table status clears when load completes
// - Negotiation pending follows negotiation, resets zero
`ifndef VCRRB_DEFS_SVH
`define VCRRB_DEFS_SVH

// ==========================================
// Offsets
`define VCRRB_CAP_OFFSET 12'h150
`define VCRRB_CTL_OFFSET 12'h154
`define VCRRB_STS_OFFSET 12'h158

// ==========================================
// Capability fields
`define VCRRB_CAP_ARB_LSB 0
`define VCRRB_CAP_ARB_RST 8'h09
`define VCRRB_CAP_ASO_BIT 14
`define VCRRB_CAP_SNOOP_BIT 15
`define VCRRB_CAP_SLOTS_LSB 16
`define VCRRB_CAP_SLOTS_RST 7'h7f
`define VCRRB_CAP_TBLOFS_LSB 24
`define VCRRB_CAP_TBLOFS_RST 8'h04

// ==========================================
// Control fields
`define VCRRB_CTL_MAP_LSB 0
`define VCRRB_CTL_MAP_RST 8'hff
`define VCRRB_CTL_LOAD_BIT 16
`define VCRRB_CTL_SEL_LSB 17
`define VCRRB_CTL_SEL_RST 3'h0
`define VCRRB_CTL_ID_LSB 24
`define VCRRB_CTL_ID_VAL 3'h0
`define VCRRB_CTL_EN_BIT 31
`define VCRRB_CTL_EN_RST 1'b1

// ==========================================
// Status fields
`define VCRRB_STS_TBL_BIT 16
`define VCRRB_STS_NEG_BIT 17

// ==========================================
// Defined bits per word; every other bit is reserved and reads zero
`define VCRRB_CAP_DEFINED 32'hff7fc0ff
`define VCRRB_CTL_DEFINED 32'h870f00ff
`define VCRRB_STS_DEFINED 32'h00030000

`endif

// ==== logic/vcrrb_pkg.sv ====
// Types for the default channel resource register bank.
// Assumes vcrrb_defs.svh is compiled with it.
package vcrrb_pkg;
  // Supported port arbitration schemes on the default channel
  typedef enum logic [2:0] {
    VCRRB_SCH_HW_FIXED = 3'h0,
    VCRRB_SCH_WRR128 = 3'h3
  } vcrrb_scheme_e;

  typedef enum {
    VCRRB_LD_IDLE,
    VCRRB_LD_BUSY
  } vcrrb_load_e;

  typedef struct packed {
    logic [7:0] tc_map;
    vcrrb_scheme_e scheme;
    logic enable;
    logic [6:0] max_slots;
    logic tbl_status;
    logic neg_pending;
    vcrrb_load_e load_state;
    logic load_pulse;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } vcrrb_state_s;
endpackage

// ==== logic/vcrrb_bank.sv ====
// Default channel resource register bank: capability, control, status.
// Assumes an APB master on sys_clk and a table loader that reports done.
// Every access answers with a one-cycle pready after one wait cycle.
// The autoload port overwrites map and slots at any time; a software write in the same cycle wins.
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
`include "vcrrb_defs.svh"

module vcrrb_bank
  import vcrrb_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration-memory autoload of defaults
  input wire logic cfg_load_valid,
  input wire logic [7:0] cfg_tc_map,
  input wire logic [6:0] cfg_max_slots,
  // Arbitration table side
  input wire logic tbl_entry_written,
  input wire logic tbl_load_done,
  output logic tbl_load_start,
  // Negotiation
  input wire logic neg_busy,
  // Channel configuration to the core
  output logic [7:0] traffic_class_route_map,
  output logic [2:0] arb_scheme,
  output logic channel_enable_bit
);

  // Paddr[11:2] selects the word, so a narrower bus cannot reach the bank
  if (ADDR_W < 12) begin : g_bad_addr_w
    $error("vcrrb_bank: ADDR_W must be at least 12");
  end

  if (ADDR_W > 32) begin : g_wide_addr_w
    $error("vcrrb_bank: ADDR_W must be at most 32");
  end

  vcrrb_state_s state_reg;
  vcrrb_state_s state_next;

  // ==========================================
  // Register images
  function automatic logic [31:0] cap_word(input logic [6:0] slots);
    logic [31:0] w;
    w = 32'h0;
    w[`VCRRB_CAP_ARB_LSB +: 8] = `VCRRB_CAP_ARB_RST;
    w[`VCRRB_CAP_ASO_BIT] = 1'b0;
    w[`VCRRB_CAP_SNOOP_BIT] = 1'b0;
    w[`VCRRB_CAP_SLOTS_LSB +: 7] = slots;
    w[`VCRRB_CAP_TBLOFS_LSB +: 8] = `VCRRB_CAP_TBLOFS_RST;
    return w;
  endfunction

  function automatic logic [31:0] ctl_word(input vcrrb_state_s s);
    logic [31:0] w;
    w = 32'h0;
    w[`VCRRB_CTL_MAP_LSB +: 8] = s.tc_map;
    w[`VCRRB_CTL_LOAD_BIT] = 1'b0;
    w[`VCRRB_CTL_SEL_LSB +: 3] = s.scheme;
    w[`VCRRB_CTL_ID_LSB +: 3] = `VCRRB_CTL_ID_VAL;
    w[`VCRRB_CTL_EN_BIT] = s.enable;
    return w;
  endfunction

  function automatic logic [31:0] sts_word(input vcrrb_state_s s);
    logic [31:0] w;
    w = 32'h0;
    w[`VCRRB_STS_TBL_BIT] = s.tbl_status;
    w[`VCRRB_STS_NEG_BIT] = s.neg_pending;
    return w;
  endfunction

  // Unlisted values, including time-based WRR, fall back to default
  function automatic vcrrb_scheme_e scheme_filter(input logic [2:0] v);
    vcrrb_scheme_e r;
    r = VCRRB_SCH_HW_FIXED;
    if (v == 3'(VCRRB_SCH_WRR128)) begin
      r = VCRRB_SCH_WRR128;
    end
    return r;
  endfunction

  // ==========================================
  // Decode helpers
  localparam int LANES = 4;
  localparam int LANE_W = 8;

  if (LANES * LANE_W != 32) begin : g_bad_lanes
    $error("vcrrb_bank: byte lanes must cover the 32-bit word");
  end

  logic access;
  logic wr_access;
  logic [11:0] word_addr;
  logic [LANES-1:0] lane_wr;

  // Paddr bits above 11 are ignored, so the bank aliases in a wider window;
  // the decoder that drives psel has to qualify the upper bits
  function automatic logic [11:0] word_of(input logic [ADDR_W-1:0] a);
    logic [11:0] w;
    w = {a[11:2], 2'b00};
    return w;
  endfunction

  // Unmapped words answer with an error and have no effect
  function automatic logic is_mapped(input logic [11:0] w);
    logic hit;
    hit = 1'b0;
    unique case (w)
      `VCRRB_CAP_OFFSET: begin
        hit = 1'b1;
      end
      `VCRRB_CTL_OFFSET: begin
        hit = 1'b1;
      end
      `VCRRB_STS_OFFSET: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // Defined bits of each word
  function automatic logic [31:0] defined_bits(input logic [11:0] w);
    logic [31:0] m;
    m = 32'h0;
    unique case (w)
      `VCRRB_CAP_OFFSET: begin
        m = `VCRRB_CAP_DEFINED;
      end
      `VCRRB_CTL_OFFSET: begin
        m = `VCRRB_CTL_DEFINED;
      end
      `VCRRB_STS_OFFSET: begin
        m = `VCRRB_STS_DEFINED;
      end
      default: begin
        m = 32'h0;
      end
    endcase
    return m;
  endfunction

  // The mask keeps reserved bits at zero even if a field constant drifts
  function automatic logic [31:0] read_word(input vcrrb_state_s s, input logic [11:0] w);
    logic [31:0] r;
    r = 32'h0;
    unique case (w)
      `VCRRB_CAP_OFFSET: begin
        r = cap_word(s.max_slots);
      end
      `VCRRB_CTL_OFFSET: begin
        r = ctl_word(s);
      end
      `VCRRB_STS_OFFSET: begin
        r = sts_word(s);
      end
      default: begin
        r = 32'h0;
      end
    endcase
    return r & defined_bits(w);
  endfunction

  // Error stands for exactly the one cycle that pready is high, read data holds until the next answer;
  // write data is never echoed on the read bus
  function automatic vcrrb_state_s bus_answer(
    input vcrrb_state_s cur,
    input vcrrb_state_s nxt,
    input logic take,
    input logic wr,
    input logic [11:0] w
  );
    vcrrb_state_s r;
    r = nxt;
    r.pready = take;
    r.pslverr = 1'b0;
    if (take) begin
      r.prdata = read_word(cur, w);
      r.pslverr = !is_mapped(w);
      if (wr) begin
        r.prdata = 32'h0;
      end
    end
    return r;
  endfunction

  // Autoload overwrites the current map and slot count; a software write in the same cycle
  // is applied after it and wins
  function automatic vcrrb_state_s autoload(
    input vcrrb_state_s s,
    input logic valid,
    input logic [7:0] map,
    input logic [6:0] slots
  );
    vcrrb_state_s r;
    r = s;
    if (valid) begin
      r.tc_map = map;
      r.max_slots = slots;
    end
    return r;
  endfunction

  // Only the control word has writable fields; writes to the capability and
  // status words complete without error and change nothing
  function automatic vcrrb_state_s ctl_write(
    input vcrrb_state_s s,
    input logic [31:0] wd,
    input logic [LANES-1:0] lanes
  );
    vcrrb_state_s r;
    r = s;
    if (lanes[0]) begin
      r.tc_map = wd[`VCRRB_CTL_MAP_LSB +: 8];
    end
    if (lanes[2]) begin
      r.scheme = scheme_filter(wd[`VCRRB_CTL_SEL_LSB +: 3]);
      if (wd[`VCRRB_CTL_LOAD_BIT]) begin
        r.load_pulse = 1'b1;
        r.load_state = VCRRB_LD_BUSY;
      end
    end
    if (lanes[3]) begin
      r.enable = wd[`VCRRB_CTL_EN_BIT];
    end
    return r;
  endfunction

  // Every reset value in one place; the reset branch loads it whole
  function automatic vcrrb_state_s reset_image();
    vcrrb_state_s r;
    r = '0;
    r.tc_map = `VCRRB_CTL_MAP_RST;
    r.scheme = vcrrb_scheme_e'(`VCRRB_CTL_SEL_RST);
    r.enable = `VCRRB_CTL_EN_RST;
    r.max_slots = `VCRRB_CAP_SLOTS_RST;
    r.tbl_status = 1'b0;
    r.neg_pending = 1'b0;
    r.load_state = VCRRB_LD_IDLE;
    r.load_pulse = 1'b0;
    r.pready = 1'b0;
    r.pslverr = 1'b0;
    r.prdata = 32'h0;
    return r;
  endfunction

  // A new load command in the cycle the old load finishes keeps the loader
  // busy, so that command is not lost; a table write in that cycle wins
  function automatic vcrrb_state_s table_track(
    input vcrrb_state_s cur,
    input vcrrb_state_s nxt,
    input logic written,
    input logic done
  );
    vcrrb_state_s r;
    r = nxt;
    unique case (cur.load_state)
      VCRRB_LD_IDLE: begin
      end
      VCRRB_LD_BUSY: begin
        if (done) begin
          r.tbl_status = 1'b0;
          if (!nxt.load_pulse) begin
            r.load_state = VCRRB_LD_IDLE;
          end
        end
      end
    endcase
    if (written) begin
      r.tbl_status = 1'b1;
    end
    return r;
  endfunction

  // ==========================================
  // Access decode
  assign access = psel && penable && !state_reg.pready;
  assign wr_access = access && pwrite;
  assign word_addr = word_of(paddr);

  // A lane is written only in the wait cycle of a write access
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    assign lane_wr[g] = wr_access && pstrb[g];
  end

  // ==========================================
  // Next state
  always_comb begin
    state_next = state_reg;
    state_next.load_pulse = 1'b0;
    state_next.neg_pending = neg_busy;
    state_next = autoload(state_next, cfg_load_valid, cfg_tc_map, cfg_max_slots);

    // Register-bus answer, then control writes on top of it
    state_next = bus_answer(state_reg, state_next, access, pwrite, word_addr);
    if (access && word_addr == `VCRRB_CTL_OFFSET) begin
      state_next = ctl_write(state_next, pwdata, lane_wr);
    end

    // Table status tracking
    state_next = table_track(state_reg, state_next, tbl_entry_written, tbl_load_done);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= reset_image();
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================
  // Outputs, all straight from flops
  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign tbl_load_start = state_reg.load_pulse;
  assign traffic_class_route_map = state_reg.tc_map;
  assign arb_scheme = state_reg.scheme;
  assign channel_enable_bit = state_reg.enable;

endmodule // vcrrb_bank

// ==== tb/vcrrb_bank_assertions.sv ====
// Port checker for the default channel register bank.
// Assumes APB requests stay held through the pready cycle.
`timescale 1ns/10ps
module vcrrb_bank_assertions (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core side
  input wire logic tbl_load_start,
  input wire logic [7:0] traffic_class_route_map,
  input wire logic [2:0] arb_scheme,
  input wire logic channel_enable_bit
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic rd = pready && !pwrite;
  wire logic wc = pready && pwrite && paddr == 12'h154;
  // ========================================
  // Read values
  chk_cap_fixed: assert property (rd && paddr == 12'h150 |->
    (prdata & 32'hff80ffff) == 32'h04000009) else $error("cap bad");
  chk_ctl_zeros: assert property (rd && paddr == 12'h154 |->
    (prdata & 32'h7ff1ff00) == 0) else $error("ctl bad");
  chk_sts_rsvd: assert property (rd && paddr == 12'h158 |->
    (prdata & 32'hfffcffff) == 0) else $error("sts bad");
  chk_err_place: assert property (pslverr |-> pready && paddr != 12'h150
    && paddr != 12'h154 && paddr != 12'h158) else $error("err bad");
  // ========================================
  // Control outputs
  chk_sch_legal: assert property (arb_scheme == 3'h0 || arb_scheme == 3'h3)
    else $error("scheme bad");
  chk_map_write: assert property (wc && pstrb[0] |->
    traffic_class_route_map == pwdata[7:0]) else $error("map bad");
  chk_sch_write: assert property (wc && pstrb[2] |->
    arb_scheme == (pwdata[19:17] == 3'h3 ? 3'h3 : 3'h0)) else $error("sel bad");
  chk_en_write: assert property (wc && pstrb[3] |->
    channel_enable_bit == pwdata[31]) else $error("enable bad");
  chk_load_pulse: assert property (tbl_load_start |->
    wc && pwdata[16] ##1 !tbl_load_start) else $error("load bad");
  cover property (tbl_load_start);
  cover property (pslverr);
  cover property (wc && pwdata[19:17] == 3'h3);
endmodule // vcrrb_bank_assertions

// ==== tb/testbench.sv ====
// Self-checking bench for the default channel register bank.
// Assumes design files compiled first; bench drives every port.
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
  $display("Error %0t got %h exp %h", $time, a, e); end end
module testbench;
  import vcrrb_pkg::*;
  logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, cfg_load_valid = 0;
  logic tbl_entry_written = 0, tbl_load_done = 0, neg_busy = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, d, c;
  logic [3:0] pstrb = 4'hf;
  logic [7:0] cfg_tc_map = 0, m, traffic_class_route_map;
  logic [6:0] cfg_max_slots = 0;
  logic pready, pslverr, tbl_load_start, channel_enable_bit;
  logic [2:0] arb_scheme;
  logic [32:0] q[$], x;
  int fail_count = 0, n_compared = 0, n_load = 0;
  integer seed = 32'h8699c5b6;
  always #20 sys_clk = ~sys_clk;
  vcrrb_bank u_vcrrb_bank (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .cfg_load_valid, .cfg_tc_map, .cfg_max_slots,
    .tbl_entry_written, .tbl_load_done, .tbl_load_start, .neg_busy,
    .traffic_class_route_map, .arb_scheme, .channel_enable_bit);
  task automatic tally_and_finish;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Each access notes {pslverr, prdata} expected at pready
  task automatic apb(logic w, logic [11:0] a, logic [31:0] wd, logic [32:0] e);
    int n;
    n = 0;
    @(posedge sys_clk);
    q.push_back(e);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    psel <= 0;
    penable <= 0;
  endtask
  always @(posedge sys_clk) begin
    if (tbl_load_start === 1'b1) n_load++;
  end
  always @(posedge sys_clk) begin
    if (pready === 1'b1 && q.size() > 0) begin
      x = q.pop_front();
      `CHK({pslverr, prdata}, x)
    end
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1;
    apb(0, 12'h150, 0, 33'h0047f0009);
    apb(0, 12'h154, 0, 33'h0800000ff);
    apb(0, 12'h158, 0, 33'h0);
    apb(1, 12'h150, '1, 33'h0);
    apb(0, 12'h150, 0, 33'h0047f0009);
    apb(0, 12'h15c, 0, 33'h100000000);
    for (int s = 0; s < 8; s++) begin
      d = $random(seed);
      d[19:16] = {s[2:0], 1'b0};
      c = {d[31], 11'h0, (s == 3) ? 3'h3 : 3'h0, 9'h0, d[7:0]};
      apb(1, 12'h154, d, 33'h0);
      apb(0, 12'h154, 0, {1'b0, c});
      `CHK({channel_enable_bit, arb_scheme}, {c[31], c[19:17]})
      `CHK(traffic_class_route_map, c[7:0])
    end
    pstrb <= 4'h1;
    apb(1, 12'h154, ~c, 33'h0);
    pstrb <= 4'hf;
    apb(0, 12'h154, 0, {1'b0, c[31:8], ~c[7:0]});
    m = $random(seed);
    @(posedge sys_clk);
    cfg_load_valid <= 1;
    cfg_tc_map <= m;
    cfg_max_slots <= ~m[6:0];
    @(posedge sys_clk);
    cfg_load_valid <= 0;
    apb(0, 12'h150, 0, {10'h008, ~m[6:0], 16'h0009});
    apb(0, 12'h154, 0, {1'b0, c[31:8], m});
    `CHK(traffic_class_route_map, m)
    neg_busy <= 1;
    apb(0, 12'h158, 0, 33'h000020000);
    neg_busy <= 0;
    @(posedge sys_clk);
    tbl_entry_written <= 1;
    @(posedge sys_clk);
    tbl_entry_written <= 0;
    tbl_load_done <= 1;
    @(posedge sys_clk);
    tbl_load_done <= 0;
    apb(0, 12'h158, 0, 33'h000010000);
    apb(1, 12'h154, {c[31:17], 1'b1, c[15:8], m}, 33'h0);
    tbl_load_done <= 1;
    @(posedge sys_clk);
    tbl_load_done <= 0;
    apb(0, 12'h158, 0, 33'h0);
    apb(0, 12'h154, 0, {1'b0, c[31:8], m});
    `CHK(n_load, 1)
    rst_n <= 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1;
    apb(0, 12'h154, 0, 33'h0800000ff);
    apb(0, 12'h150, 0, 33'h0047f0009);
    tally_and_finish();
  end
endmodule // testbench
bind vcrrb_bank vcrrb_bank_assertions u_chk (.sys_clk, .rst_n, .pwrite, .paddr, .pwdata,
  .pstrb, .prdata, .pready, .pslverr, .tbl_load_start, .traffic_class_route_map,
  .arb_scheme, .channel_enable_bit);
